/* File: design/opcd_params.svh */
// Register map, field positions and reset values of the output pair divider
`ifndef OPCD_PARAMS_SVH
`define OPCD_PARAMS_SVH
// Register indices; byte address is four times the index
`define OPCD_IDX_DIV1_CYCLES 12'h193
`define OPCD_IDX_DIV1_CTRL 12'h194
`define OPCD_IDX_DIV1_ROUTE 12'h195
`define OPCD_IDX_DIV2_CYCLES 12'h196
`define OPCD_IDX_DIV2_CTRL 12'h197
`define OPCD_IDX_DIV2_ROUTE 12'h198
// Cycle count fields
`define OPCD_LOW_MSB 7
`define OPCD_LOW_LSB 4
`define OPCD_HIGH_MSB 3
`define OPCD_HIGH_LSB 0
// Control fields
`define OPCD_BYPASS_BIT 7
`define OPCD_IGNORE_BIT 6
`define OPCD_FORCE_BIT 5
`define OPCD_START_BIT 4
`define OPCD_PHASE_MSB 3
`define OPCD_PHASE_LSB 0
// Route fields
`define OPCD_DIRECT_BIT 1
`define OPCD_DUTY_CORRECTION_DISABLE_BIT 0
// Source select codes and bits
`define OPCD_SRC_OSC_DIRECT 2'h2
`define OPCD_SRC_EXT_DIRECT 2'h0
`define OPCD_SRC_OSC_BIT 1
`define OPCD_SRC_PRESC_BYP_BIT 0
// Reset values
`define OPCD_RST_DIV1_CYCLES 8'hBB
`define OPCD_RST_DIV2_CYCLES 8'h00
`define OPCD_RST_CTRL 8'h00
`define OPCD_RST_ROUTE 8'h00
// AXI responses
`define OPCD_RESP_OKAY 2'h0
`define OPCD_RESP_SLVERR 2'h2
`endif

/* File: design/opcd_pkg.sv */
// Types shared by the output pair divider
package opcd_pkg;
    // Control register view
    typedef struct packed {
        logic bypass;
        logic ignore_align;
        logic force_high;
        logic start_high;
        logic [3:0] phase;
    } opcd_ctl_t;
    // Differential output pair
    typedef struct packed {
        logic out_a;
        logic out_b;
    } opcd_pair_t;
    // One-hot divider states
    typedef enum logic [3:0] {
        OPCD_HOLD = 4'h1,
        OPCD_PHASE = 4'h2,
        OPCD_HIGH = 4'h4,
        OPCD_LOW = 4'h8
    } opcd_state_t;
endpackage

/* File: design/opcd_top.sv */
// Two output pair clock dividers with AXI4-Lite control registers
//
// Functional notes
// - Low phase lasts low field plus one
// - High phase lasts high field plus one
// - Bypass passes input clock to output
// - Divider 2 bypass resets to zero
// - Ignore bit makes channel skip alignment
// - Force bit sets static output level while held, or high with ignore bit
// - Force bit ignored while bypassed
// - Start bit picks initial output level
// - Four-bit phase offset, reset zero
// - Direct bit with 10b routes oscillator
// - Direct bit with 00b routes external clock
// - Select 01b keeps pair on divider
// - Correction on unless disable bit set
// - Divider 1 to pair B, 2 to C
// - Source select picks clock, prescaler bypass
// - Alignment holds channels, release restarts together
`timescale 1ns/1ps
`include "opcd_params.svh"
module opcd_top #(
    parameter int CH_N = 2,
    parameter int CNT_W = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] src_sel,
    input wire logic osc_clk_lvl,
    input wire logic ext_clk_lvl,
    input wire logic presc_clk_lvl,
    input wire logic align_hold,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pair_b_output_a,
    output logic pair_b_output_b,
    output logic pair_c_output_a,
    output logic pair_c_output_b,
    output logic pair_b_dcc_en,
    output logic pair_c_dcc_en
);
    import opcd_pkg::*;

    // Per channel register copies
    logic [7:0] cyc_reg [CH_N];
    logic [7:0] ctl_reg [CH_N];
    logic [7:0] rte_reg [CH_N];
    // Register outputs of each channel
    opcd_pair_t pair_reg [CH_N];
    logic dcc_reg [CH_N];
    // Bus handshake state
    logic bvalid_reg;
    logic rvalid_reg;
    logic [1:0] bresp_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    // Previous input levels for edge finding
    logic div_in_prev_reg;
    // Decoded write and read targets
    logic wr_fire;
    logic rd_fire;
    logic [11:0] wr_idx;
    logic [11:0] rd_idx;
    logic wr_hit;
    logic [1:0] wr_ch;
    logic [1:0] wr_kind;
    logic rd_hit;
    logic [7:0] rd_val;
    // Divider input clock and its rising edge
    logic sel_raw;
    logic div_in;
    logic in_tick;

    // Write taken when address and data both present
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign s_axi_arready = rd_fire;
    assign wr_idx = s_axi_awaddr[13:2];
    assign rd_idx = s_axi_araddr[13:2];
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // Write address decode to channel and register kind
    always_comb begin
        wr_hit = 1'b1;
        wr_ch = 2'h0;
        wr_kind = 2'h0;
        case (wr_idx)
            `OPCD_IDX_DIV1_CYCLES: begin
                wr_kind = 2'h0;
            end
            `OPCD_IDX_DIV1_CTRL: begin
                wr_kind = 2'h1;
            end
            `OPCD_IDX_DIV1_ROUTE: begin
                wr_kind = 2'h2;
            end
            `OPCD_IDX_DIV2_CYCLES: begin
                wr_ch = 2'h1;
                wr_kind = 2'h0;
            end
            `OPCD_IDX_DIV2_CTRL: begin
                wr_ch = 2'h1;
                wr_kind = 2'h1;
            end
            `OPCD_IDX_DIV2_ROUTE: begin
                wr_ch = 2'h1;
                wr_kind = 2'h2;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Read mux; unused route bits read zero
    always_comb begin
        rd_hit = 1'b1;
        case (rd_idx)
            `OPCD_IDX_DIV1_CYCLES: rd_val = cyc_reg[0];
            `OPCD_IDX_DIV1_CTRL: rd_val = ctl_reg[0];
            `OPCD_IDX_DIV1_ROUTE: rd_val = rte_reg[0];
            `OPCD_IDX_DIV2_CYCLES: rd_val = cyc_reg[1];
            `OPCD_IDX_DIV2_CTRL: rd_val = ctl_reg[1];
            `OPCD_IDX_DIV2_ROUTE: rd_val = rte_reg[1];
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Write response channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `OPCD_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `OPCD_RESP_OKAY : `OPCD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read data channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `OPCD_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? `OPCD_RESP_OKAY : `OPCD_RESP_SLVERR;
            rdata_reg <= {24'h00_0000, rd_val};
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign sel_raw = src_sel[`OPCD_SRC_OSC_BIT] ? osc_clk_lvl : ext_clk_lvl;
    assign div_in = src_sel[`OPCD_SRC_PRESC_BYP_BIT] ? sel_raw : presc_clk_lvl;
    assign in_tick = div_in && !div_in_prev_reg;

    // Input level history
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_in_prev_reg <= 1'b0;
        end else begin
            div_in_prev_reg <= div_in;
        end
    end

    // One divider per channel
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        opcd_ctl_t ctl;
        opcd_state_t state_reg;
        logic [CNT_W-1:0] cnt_reg;
        logic [CNT_W-1:0] hi_cnt;
        logic [CNT_W-1:0] lo_cnt;
        logic held;
        logic div_lvl;
        logic out_lvl;
        logic direct;
        logic wr_me;

        assign ctl = opcd_ctl_t'(ctl_reg[c]);
        assign hi_cnt = cyc_reg[c][`OPCD_HIGH_MSB:`OPCD_HIGH_LSB];
        assign lo_cnt = cyc_reg[c][`OPCD_LOW_MSB:`OPCD_LOW_LSB];
        assign wr_me = wr_fire && wr_hit && s_axi_wstrb[0] && (wr_ch == 2'(c));
        assign held = align_hold && !ctl.ignore_align;

        // Register storage for this channel
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                // Divider 2 bypass and counts reset to zero
                cyc_reg[c] <= (c == 0) ? `OPCD_RST_DIV1_CYCLES : `OPCD_RST_DIV2_CYCLES;
                ctl_reg[c] <= `OPCD_RST_CTRL;
                rte_reg[c] <= `OPCD_RST_ROUTE;
            end else if (wr_me) begin
                if (wr_kind == 2'h0) begin
                    cyc_reg[c] <= s_axi_wdata[7:0];
                end else if (wr_kind == 2'h1) begin
                    ctl_reg[c] <= s_axi_wdata[7:0];
                end else begin
                    rte_reg[c] <= {6'h00, s_axi_wdata[1:0]};
                end
            end
        end

        // Divider phase sequencer
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                state_reg <= OPCD_HOLD;
                cnt_reg <= '0;
            end else if (ctl.bypass || held || (ctl.ignore_align && ctl.force_high)) begin
                state_reg <= OPCD_HOLD;
                cnt_reg <= ctl.phase;
            end else if (state_reg == OPCD_HOLD) begin
                // Restart at start level after phase delay
                if (ctl.phase != '0) begin
                    state_reg <= OPCD_PHASE;
                    cnt_reg <= ctl.phase - 1'b1;
                end else begin
                    state_reg <= ctl.start_high ? OPCD_HIGH : OPCD_LOW;
                    cnt_reg <= ctl.start_high ? hi_cnt : lo_cnt;
                end
            end else if (in_tick) begin
                case (state_reg)
                    OPCD_PHASE: begin
                        if (cnt_reg == '0) begin
                            state_reg <= ctl.start_high ? OPCD_HIGH : OPCD_LOW;
                            cnt_reg <= ctl.start_high ? hi_cnt : lo_cnt;
                        end else begin
                            cnt_reg <= cnt_reg - 1'b1;
                        end
                    end
                    // High phase of high field plus one
                    OPCD_HIGH: begin
                        if (cnt_reg == '0) begin
                            state_reg <= OPCD_LOW;
                            cnt_reg <= lo_cnt;
                        end else begin
                            cnt_reg <= cnt_reg - 1'b1;
                        end
                    end
                    // Low phase of low field plus one
                    OPCD_LOW: begin
                        if (cnt_reg == '0) begin
                            state_reg <= OPCD_HIGH;
                            cnt_reg <= hi_cnt;
                        end else begin
                            cnt_reg <= cnt_reg - 1'b1;
                        end
                    end
                    default: begin
                        state_reg <= OPCD_HOLD;
                    end
                endcase
            end
        end

        // Divider output level selection
        always_comb begin
            if (ctl.bypass) begin
                div_lvl = div_in;
            end else if (held || (ctl.ignore_align && ctl.force_high)) begin
                div_lvl = ctl.force_high;
            end else if (state_reg == OPCD_HIGH) begin
                div_lvl = 1'b1;
            end else if (state_reg == OPCD_LOW) begin
                div_lvl = 1'b0;
            end else begin
                div_lvl = ctl.start_high;
            end
        end

        assign direct = rte_reg[c][`OPCD_DIRECT_BIT] &&
                        ((src_sel == `OPCD_SRC_OSC_DIRECT) || (src_sel == `OPCD_SRC_EXT_DIRECT));
        assign out_lvl = !direct ? div_lvl :
                         (src_sel == `OPCD_SRC_OSC_DIRECT) ? osc_clk_lvl : ext_clk_lvl;

        // Registered pair and correction enable
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                pair_reg[c] <= '{out_a: 1'b0, out_b: 1'b1};
                dcc_reg[c] <= 1'b1;
            end else begin
                pair_reg[c] <= '{out_a: out_lvl, out_b: !out_lvl};
                dcc_reg[c] <= !rte_reg[c][`OPCD_DUTY_CORRECTION_DISABLE_BIT];
            end
        end
    end

    // Divider 1 feeds pair B, divider 2 pair C
    assign pair_b_output_a = pair_reg[0].out_a;
    assign pair_b_output_b = pair_reg[0].out_b;
    assign pair_c_output_a = pair_reg[1].out_a;
    assign pair_c_output_b = pair_reg[1].out_b;
    assign pair_b_dcc_en = dcc_reg[0];
    assign pair_c_dcc_en = dcc_reg[1];
endmodule

/* File: dv/opcd_top_sva.sv */
// Checker for the divider bus handshakes and output pins
`timescale 1ns/1ps
module opcd_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pair_b_output_a,
    input wire logic pair_b_output_b,
    input wire logic pair_c_output_a,
    input wire logic pair_c_output_b,
    input wire logic pair_c_dcc_en
);
    // Single clock domain
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Write request taken
    sequence s_wr;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    // Write response accepted
    sequence s_bdone;
        s_axi_bvalid && s_axi_bready;
    endsequence
    property p_b_pair; pair_b_output_b == !pair_b_output_a; endproperty
    property p_c_pair; pair_c_output_b == !pair_c_output_a; endproperty
    property p_wr_ans; s_wr |=> s_axi_bvalid; endproperty
    property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_wr_end; s_bdone |=> !s_axi_bvalid; endproperty
    property p_wr_block; s_axi_bvalid |-> !s_axi_awready; endproperty
    property p_rd_ans; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    // Correction enable moves only after a write
    property p_dcc;
        $changed(pair_c_dcc_en) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endproperty
    a_b_pair: assert property (p_b_pair) else $error("pair b not complementary");
    a_c_pair: assert property (p_c_pair) else $error("pair c not complementary");
    a_wr_ans: assert property (p_wr_ans) else $error("write response late");
    a_wr_hold: assert property (p_wr_hold) else $error("bvalid dropped early");
    a_wr_end: assert property (p_wr_end) else $error("bvalid stuck");
    a_wr_block: assert property (p_wr_block) else $error("awready while busy");
    a_rd_ans: assert property (p_rd_ans) else $error("read response late");
    a_rd_hold: assert property (p_rd_hold) else $error("rvalid dropped early");
    a_dcc: assert property (p_dcc) else $error("dcc enable moved alone");
endmodule
bind opcd_top opcd_sva u_sva (
    .clk_sys(clk_sys),
    .rst(rst),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .pair_b_output_a(pair_b_output_a),
    .pair_b_output_b(pair_b_output_b),
    .pair_c_output_a(pair_c_output_a),
    .pair_c_output_b(pair_c_output_b),
    .pair_c_dcc_en(pair_c_dcc_en)
);

/* File: dv/tb.sv */
// Self-checking bench for the output pair divider
`timescale 1ns/1ps
`include "opcd_params.svh"
module tb;
    import opcd_pkg::*;
    logic clk_sys = 0, rst = 1, align_hold = 0;
    logic [1:0] src_sel = 0, ph = 0, s_axi_bresp, s_axi_rresp;
    logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic pair_b_output_a, pair_b_output_b, pair_c_output_a, pair_c_output_b;
    logic pair_b_dcc_en, pair_c_dcc_en;
    int err_total = 0, cmp_count = 0;
    // Source levels: osc and prescaler period 2, external period 4
    wire osc_clk_lvl = ph[0];
    wire presc_clk_lvl = ph[0];
    wire ext_clk_lvl = ph[1];
    opcd_top uut (.*);
    // Clock
    initial forever #50 clk_sys = ~clk_sys;
    // Level generator
    always @(posedge clk_sys) begin
        ph <= ph + 2'h1;
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task tmo;
        err_total++;
        print_verdict;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Selected pair true output
    function logic o(input logic c);
        return c ? pair_c_output_a : pair_b_output_a;
    endfunction
    // Bus write, both channels offered together
    task wr(input logic [11:0] i, input logic [7:0] d, input logic [3:0] s,
            input logic [1:0] r);
        int n;
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        n = 0;
        do @(negedge clk_sys); while (s_axi_awready !== 1'h1 && n++ < 50);
        @(posedge clk_sys);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(negedge clk_sys); while (s_axi_bvalid !== 1'h1 && n++ < 50);
        // Response left waiting one cycle before it is accepted
        @(posedge clk_sys);
        s_axi_bready <= 1'h1;
        @(negedge clk_sys);
        chk(s_axi_bresp, r);
        @(posedge clk_sys);
        s_axi_bready <= 1'h0;
        if (n >= 50) tmo;
    endtask
    // Bus read with expected byte and response
    task rd(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r);
        int n;
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        n = 0;
        do @(negedge clk_sys); while (s_axi_arready !== 1'h1 && n++ < 50);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'h0;
        do @(negedge clk_sys); while (s_axi_rvalid !== 1'h1 && n++ < 50);
        // Read data left waiting one cycle before it is accepted
        @(posedge clk_sys);
        s_axi_rready <= 1'h1;
        @(negedge clk_sys);
        chk(s_axi_rdata, {24'h0, d});
        chk(s_axi_rresp, r);
        @(posedge clk_sys);
        s_axi_rready <= 1'h0;
        if (n >= 50) tmo;
    endtask
    // Measure high and low run lengths in clock cycles
    task ms(input logic c, input int h, input int l);
        int n, k;
        n = 0;
        repeat (4) @(posedge clk_sys);
        do @(negedge clk_sys); while (o(c) !== 1'h0 && n++ < 200);
        do @(negedge clk_sys); while (o(c) !== 1'h1 && n++ < 200);
        k = 0;
        do begin @(negedge clk_sys); k++; end while (o(c) === 1'h1 && k < 200);
        chk(k, h);
        k = 0;
        do begin @(negedge clk_sys); k++; end while (o(c) === 1'h0 && k < 200);
        chk(k, l);
        @(posedge clk_sys);
        if (n >= 200) tmo;
    endtask
    // Static level held for 20 cycles
    task st(input logic c, input logic v);
        int k;
        k = 0;
        repeat (20) begin @(negedge clk_sys); k += (o(c) !== v); end
        chk(k, 0);
        @(posedge clk_sys);
    endtask
    task test_reset;
        rd(`OPCD_IDX_DIV1_CYCLES, 8'hBB, `OPCD_RESP_OKAY);
        for (int i = 12'h194; i <= 12'h198; i++) rd(12'(i), 8'h00, `OPCD_RESP_OKAY);
        rd(12'h199, 8'h00, `OPCD_RESP_SLVERR);
        chk(pair_c_dcc_en, 1'h1);
        chk(pair_b_dcc_en, 1'h1);
        ms(0, 24, 24);
        ms(1, 2, 2);
        $display("test_reset done");
    endtask
    task test_div;
        logic [7:0] cv [3];
        cv = '{8'h25, 8'h0F, 8'hF0};
        foreach (cv[i]) begin
            wr(`OPCD_IDX_DIV2_CYCLES, cv[i], 4'h1, `OPCD_RESP_OKAY);
            ms(1, (cv[i][3:0] + 1) * 2, (cv[i][7:4] + 1) * 2);
        end
        wr(`OPCD_IDX_DIV2_CYCLES, 8'h33, 4'h0, `OPCD_RESP_OKAY);
        rd(`OPCD_IDX_DIV2_CYCLES, 8'hF0, `OPCD_RESP_OKAY);
        wr(12'h199, 8'h00, 4'h1, `OPCD_RESP_SLVERR);
        $display("test_div done");
    endtask
    task test_ctl;
        wr(`OPCD_IDX_DIV2_CTRL, 8'hA0, 4'h1, `OPCD_RESP_OKAY);
        ms(1, 1, 1);
        wr(`OPCD_IDX_DIV2_CTRL, 8'h60, 4'h1, `OPCD_RESP_OKAY);
        st(1, 1'h1);
        wr(`OPCD_IDX_DIV2_CTRL, 8'h00, 4'h1, `OPCD_RESP_OKAY);
        align_hold <= 1'h1;
        st(1, 1'h0);
        wr(`OPCD_IDX_DIV2_CTRL, 8'h20, 4'h1, `OPCD_RESP_OKAY);
        st(1, 1'h1);
        wr(`OPCD_IDX_DIV2_CTRL, 8'h40, 4'h1, `OPCD_RESP_OKAY);
        ms(1, 2, 32);
        st(0, 1'h0);
        $display("test_ctl done");
    endtask
    task test_phase;
        int k;
        wr(`OPCD_IDX_DIV2_CYCLES, 8'h11, 4'h1, `OPCD_RESP_OKAY);
        for (int s = 0; s < 2; s++) begin
            align_hold <= 1'h1;
            wr(`OPCD_IDX_DIV2_CTRL, {3'h0, s[0], 4'h3}, 4'h1, `OPCD_RESP_OKAY);
            repeat (4) @(posedge clk_sys);
            align_hold <= 1'h0;
            k = 0;
            do begin @(negedge clk_sys); k++; end while (o(1) !== s[0] && k < 40);
            do begin @(negedge clk_sys); k++; end while (o(1) === s[0] && k < 40);
            chk(k inside {[10:14]}, 1'h1);
            @(posedge clk_sys);
        end
        $display("test_phase done");
    endtask
    task test_route;
        wr(`OPCD_IDX_DIV2_CTRL, 8'h00, 4'h1, `OPCD_RESP_OKAY);
        wr(`OPCD_IDX_DIV2_ROUTE, 8'h02, 4'h1, `OPCD_RESP_OKAY);
        src_sel <= 2'h2;
        ms(1, 1, 1);
        src_sel <= 2'h0;
        ms(1, 2, 2);
        src_sel <= 2'h1;
        ms(1, 8, 8);
        src_sel <= 2'h0;
        wr(`OPCD_IDX_DIV2_ROUTE, 8'hFF, 4'h1, `OPCD_RESP_OKAY);
        rd(`OPCD_IDX_DIV2_ROUTE, 8'h03, `OPCD_RESP_OKAY);
        chk(pair_c_dcc_en, 1'h0);
        wr(`OPCD_IDX_DIV1_ROUTE, 8'h01, 4'h1, `OPCD_RESP_OKAY);
        rd(`OPCD_IDX_DIV1_ROUTE, 8'h01, `OPCD_RESP_OKAY);
        chk(pair_b_dcc_en, 1'h0);
        wr(`OPCD_IDX_DIV1_ROUTE, 8'h00, 4'h1, `OPCD_RESP_OKAY);
        wr(`OPCD_IDX_DIV2_ROUTE, 8'h00, 4'h1, `OPCD_RESP_OKAY);
        ms(1, 4, 4);
        $display("test_route done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        test_reset;
        test_div;
        test_ctl;
        test_phase;
        test_route;
        print_verdict;
    end
endmodule
